// *** spi_frame_slave.sv ***
// serial frame slave: 16-bit frames, write flag, 7-bit address, 8-bit data
`timescale 1ns/1ps
`include "wdbus_map.svh"
module spi_frame_slave (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  sclk,
    input  wire logic                  sdi,
    input  wire logic                  chipSelectN,
    input  wire logic [7:0]            readByte,
    output      logic [6:0]            peekAddr,
    output      wdbus_pkg::spi_frame_s frame,
    output      logic                  frameDone,
    output      logic                  frameError,
    output      logic                  sdo,
    output      logic                  sdoEnable
);
    logic        sclkPrev_reg;
    logic        csPrev_reg;
    logic [4:0]  bitCount_reg;
    logic [15:0] shiftIn_reg;
    logic [7:0]  shiftOut_reg;
    logic        csFall;
    logic        csRise;
    logic        sclkRise;
    logic        sclkFall;

    assign csFall   = csPrev_reg & ~chipSelectN;
    assign csRise   = ~csPrev_reg & chipSelectN;
    assign sclkRise = ~sclkPrev_reg & sclk & ~chipSelectN;
    assign sclkFall = sclkPrev_reg & ~sclk & ~chipSelectN;
    assign peekAddr = {shiftIn_reg[5:0], sdi};

    // edge history
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclkPrev_reg <= 1'b0;
            csPrev_reg   <= 1'b1;
        end else begin
            sclkPrev_reg <= sclk;
            csPrev_reg   <= chipSelectN;
        end
    end

    // receive shifter and bit count
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bitCount_reg <= 5'h00;
            shiftIn_reg  <= 16'h0000;
        end else if (csFall) begin
            bitCount_reg <= 5'h00;
        end else if (sclkRise) begin
            shiftIn_reg <= {shiftIn_reg[14:0], sdi};
            if (bitCount_reg != 5'h1F) begin
                bitCount_reg <= bitCount_reg + 5'h01;
            end
        end
    end

    // transmit shifter: old register contents after the address
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftOut_reg <= 8'h00;
            sdo          <= 1'b0;
        end else if (csFall) begin
            shiftOut_reg <= 8'h00;
            sdo          <= 1'b0;
        end else if (sclkRise && bitCount_reg == `WDB_ADDR_BITS) begin
            shiftOut_reg <= readByte;
        end else if (sclkFall) begin
            sdo          <= shiftOut_reg[7];
            shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
        end
    end

    // frame completion on chip select release
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame      <= '0;
            frameDone  <= 1'b0;
            frameError <= 1'b0;
            sdoEnable  <= 1'b0;
        end else begin
            sdoEnable  <= ~chipSelectN;
            frameDone  <= csRise && bitCount_reg == `WDB_FRAME_BITS;
            frameError <= csRise && bitCount_reg != `WDB_FRAME_BITS;
            if (csRise) begin
                frame <= shiftIn_reg;
            end
        end
    end

endmodule : spi_frame_slave

// *** spi_host_model.sv ***
// serial host model: drives frames into the control bank, captures the reply
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic sys_clk,
    input  wire logic sdo,
    output      logic sclk,
    output      logic sdi,
    output      logic chip_select_n
);
    initial begin
        sclk          = 1'b0;
        sdi           = 1'b0;
        chip_select_n = 1'b1;
    end

    task automatic half();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : half

    // msb first: write flag, address, data; reply is the last 8 bits
    task automatic xfer(input logic [15:0] w, output logic [7:0] r);
        logic [15:0] cap;
        cap           = 16'h0000;
        chip_select_n = 1'b0;
        half();
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            half();
            sclk = 1'b1;
            cap  = {cap[14:0], sdo};
            half();
            sclk = 1'b0;
        end
        half();
        chip_select_n = 1'b1;
        sdi           = ~sdi;
        half();
        half();
        r = cap[7:0];
    endtask : xfer
endmodule : spi_host_model

// *** tb_watchdog_bus_control_regs.sv ***
// self-checking bench for the watchdog and bus control bank
`timescale 1ns/1ps
module tb_watchdog_bus_control_regs;
    localparam logic [9:0] MS_TABLE [7] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h3E8};
    logic                 sys_clk;
    logic                 reset_n;
    logic                 softReset;
    logic                 restartEntry;
    logic                 failSafeEntry;
    wdbus_pkg::sbc_mode_e sbcMode;
    logic [1:0]           restartLinMode;
    logic [1:0]           restartCanMode;
    logic                 busWake;
    logic                 sclk;
    logic                 sdi;
    logic                 chip_select_n;
    logic                 sdo;
    logic                 sdoEnable;
    logic                 spiFail;
    logic                 stopWdogOff;
    logic                 windowTypeSelect;
    logic                 wdogLongWindowStart;
    logic [2:0]           periodSelect;
    logic [9:0]           periodMs;
    wdbus_pkg::lin_cfg_s  linCfg;
    logic [1:0]           firstLinMode;
    logic [1:0]           canMode;
    logic                 regulatorPeakThreshold;
    int                   miscompares = 0;
    int                   nCompared = 0;
    int                   failCount = 0;
    int                   longCount = 0;
    int                   enCount = 0;
    int                   prev;
    logic [1:0]           m;
    logic [7:0]           d;

    watchdog_bus_control_regs u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .softReset(softReset), .restartEntry(restartEntry),
        .failSafeEntry(failSafeEntry), .sbcMode(sbcMode), .restartLinMode(restartLinMode),
        .restartCanMode(restartCanMode), .busWake(busWake), .sclk(sclk), .sdi(sdi),
        .chip_select_n(chip_select_n), .sdo(sdo), .sdoEnable(sdoEnable), .spiFail(spiFail),
        .stopWdogOff(stopWdogOff), .windowTypeSelect(windowTypeSelect), .wdogLongWindowStart(wdogLongWindowStart),
        .periodSelect(periodSelect), .periodMs(periodMs), .linCfg(linCfg), .firstLinMode(firstLinMode),
        .canMode(canMode), .regulatorPeakThreshold(regulatorPeakThreshold));
    spi_host_model u_host (.sys_clk(sys_clk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .chip_select_n(chip_select_n));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        failCount += int'(spiFail === 1'b1);
        longCount += int'(wdogLongWindowStart === 1'b1);
        enCount += int'(sdoEnable === 1'b1);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] r;
        u_host.xfer({1'b1, a, v}, r);
    endtask : wr

    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer({1'b0, a, 8'h00}, r);
        chk(16'(r), 16'(e));
    endtask : rdchk

    // bus wake, restart, fail-safe or soft reset pulse
    task automatic pulseEv(input int w);
        case (w)
            0: busWake = 1'b1;
            1: restartEntry = 1'b1;
            2: failSafeEntry = 1'b1;
            default: softReset = 1'b1;
        endcase
        tick(1);
        busWake = 1'b0;
        restartEntry = 1'b0;
        failSafeEntry = 1'b0;
        softReset = 1'b0;
        tick(4);
    endtask : pulseEv

    function automatic logic [7:0] par(input logic [6:0] v);
        par = {^v, v};
    endfunction : par

    task summarize;
        if (miscompares == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #3_000_000;
        miscompares++;
        summarize();
    end

    initial begin
        reset_n = 1'b0;
        softReset = 1'b0;
        restartEntry = 1'b0;
        failSafeEntry = 1'b0;
        busWake = 1'b0;
        sbcMode = wdbus_pkg::SBC_INIT;
        restartLinMode = 2'h0;
        restartCanMode = 2'h0;
        tick(10);
        reset_n = 1'b1;
        tick(2);
        rdchk(7'h03, 8'h14);
        rdchk(7'h04, 8'h20);
        rdchk(7'h05, 8'h00);
        sbcMode = wdbus_pkg::SBC_NORMAL;
        for (int c = 0; c < 7; c++) begin
            d = par({3'h2, 1'b1, 3'(c)});
            wr(7'h03, d);
            chk(16'(periodSelect), 16'(c));
            chk(16'(periodMs), 16'(MS_TABLE[c]));
            chk(16'(windowTypeSelect), 16'h1);
            rdchk(7'h03, d & 8'hF7);
        end
        prev = failCount;
        wr(7'h03, par(7'h05) ^ 8'h80);
        chk(16'(failCount - prev), 16'h1);
        rdchk(7'h03, d & 8'hF7);
        prev = enCount;
        wr(7'h06, 8'hFF);
        chk(16'(enCount - prev), 16'h0088);
        rdchk(7'h06, 8'h04);
        wr(7'h03, par(7'h44));
        chk(16'(stopWdogOff), 16'h1);
        wr(7'h03, par(7'h04));
        chk(16'(stopWdogOff), 16'h0);
        wr(7'h06, 8'h00);
        wr(7'h03, par(7'h44));
        chk(16'(stopWdogOff), 16'h0);
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            d = {m[1], m[0], ~m[0], m, 1'b1, ~m};
            wr(7'h04, d);
            chk(16'(linCfg), 16'({m[1], m[0], ~m[0]}));
            chk(16'(firstLinMode), 16'(m));
            chk(16'(canMode), 16'({~m[1], ~m[0]}));
            rdchk(7'h04, d & 8'hFB);
        end
        wr(7'h05, 8'hFF);
        chk(16'(regulatorPeakThreshold), 16'h1);
        rdchk(7'h05, 8'h20);
        sbcMode = wdbus_pkg::SBC_STOP;
        prev = failCount;
        wr(7'h05, 8'h00);
        chk(16'(regulatorPeakThreshold), 16'h1);
        chk(16'(failCount - prev), 16'h0);
        prev = longCount;
        pulseEv(0);
        chk(16'(longCount - prev), 16'h0);
        wr(7'h03, par(7'h73));
        pulseEv(0);
        chk(16'(longCount - prev), 16'h1);
        wr(7'h06, 8'hFF);
        restartLinMode = 2'h2;
        restartCanMode = 2'h1;
        pulseEv(1);
        rdchk(7'h03, (par(7'h73) & 8'hB0) | 8'h04);
        rdchk(7'h04, 8'hC0 | {3'h0, restartLinMode, 1'b0, restartCanMode});
        rdchk(7'h05, 8'h20);
        chk(16'(stopWdogOff), 16'h0);
        pulseEv(2);
        rdchk(7'h04, 8'hC9);
        rdchk(7'h05, 8'h01);
        pulseEv(3);
        rdchk(7'h03, 8'h14);
        rdchk(7'h04, 8'h20);
        rdchk(7'h05, 8'h00);
        summarize();
    end
endmodule : tb_watchdog_bus_control_regs

bind watchdog_bus_control_regs wdbus_ctrl_chk u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .softReset(softReset), .restartEntry(restartEntry),
    .failSafeEntry(failSafeEntry), .sbcMode(sbcMode), .restartLinMode(restartLinMode),
    .restartCanMode(restartCanMode), .busWake(busWake), .chip_select_n(chip_select_n), .spiFail(spiFail),
    .stopWdogOff(stopWdogOff), .windowTypeSelect(windowTypeSelect), .wdogLongWindowStart(wdogLongWindowStart),
    .periodSelect(periodSelect), .periodMs(periodMs), .linCfg(linCfg), .firstLinMode(firstLinMode),
    .canMode(canMode), .regulatorPeakThreshold(regulatorPeakThreshold));

// *** watchdog_bus_control_regs.sv ***
// watchdog, bus transceiver and supply peak control registers behind the serial port
`timescale 1ns/1ps
`include "wdbus_map.svh"
module watchdog_bus_control_regs (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 softReset,
    input  wire logic                 restartEntry,
    input  wire logic                 failSafeEntry,
    input  wire wdbus_pkg::sbc_mode_e sbcMode,
    input  wire logic [1:0]           restartLinMode,
    input  wire logic [1:0]           restartCanMode,
    input  wire logic                 busWake,
    input  wire logic                 sclk,
    input  wire logic                 sdi,
    input  wire logic                 chip_select_n,
    output      logic                 sdo,
    output      logic                 sdoEnable,
    output      logic                 spiFail,
    output      logic                 stopWdogOff,
    output      logic                 windowTypeSelect,
    output      logic                 wdogLongWindowStart,
    output      logic [2:0]           periodSelect,
    output      logic [9:0]           periodMs,
    output      wdbus_pkg::lin_cfg_s  linCfg,
    output      logic [1:0]           firstLinMode,
    output      logic [1:0]           canMode,
    output      logic                 regulatorPeakThreshold
);
    logic [7:0]            watchdogControl_reg;
    logic [7:0]            watchdogControl_next;
    logic [7:0]            busTransceiverControl_reg;
    logic [7:0]            busTransceiverControl_next;
    logic [7:0]            supplyPeakControl_reg;
    logic [7:0]            supplyPeakControl_next;
    logic [7:0]            wakeControl_reg;
    logic [7:0]            wakeControl_next;
    logic [6:0]            peekAddr;
    logic [7:0]            readByte;
    wdbus_pkg::spi_frame_s frame;
    logic                  frameDone;
    logic                  frameError;
    logic                  wdWrite;
    logic                  busWrite;
    logic                  peakWrite;
    logic                  wakeWrite;
    logic                  parityBad;

    function automatic logic [9:0] period_to_ms(input logic [2:0] code);
        case (code)
            3'h0:    period_to_ms = `WDB_PERIOD_MS_0;
            3'h1:    period_to_ms = `WDB_PERIOD_MS_1;
            3'h2:    period_to_ms = `WDB_PERIOD_MS_2;
            3'h3:    period_to_ms = `WDB_PERIOD_MS_3;
            3'h4:    period_to_ms = `WDB_PERIOD_MS_4;
            3'h5:    period_to_ms = `WDB_PERIOD_MS_5;
            3'h6:    period_to_ms = `WDB_PERIOD_MS_6;
            default: period_to_ms = `WDB_PERIOD_MS_RSVD;
        endcase
    endfunction : period_to_ms

    function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                            input logic [7:0] wd,
                                            input logic [7:0] bus,
                                            input logic [7:0] peak,
                                            input logic [7:0] wake);
        case (addr)
            `WDB_ADDR_WATCHDOG: read_mux = wd;
            `WDB_ADDR_BUS:      read_mux = bus;
            `WDB_ADDR_PEAK:     read_mux = peak;
            `WDB_ADDR_WAKE:     read_mux = wake;
            default:            read_mux = 8'h00;
        endcase
    endfunction : read_mux

    spi_frame_slave u_frame (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .sclk        (sclk),
        .sdi         (sdi),
        .chipSelectN (chip_select_n),
        .readByte    (readByte),
        .peekAddr    (peekAddr),
        .frame       (frame),
        .frameDone   (frameDone),
        .frameError  (frameError),
        .sdo         (sdo),
        .sdoEnable   (sdoEnable)
    );

    // previous contents go back to the host
    assign readByte = read_mux(peekAddr, watchdogControl_reg, busTransceiverControl_reg,
                               supplyPeakControl_reg, wakeControl_reg);

    // write decode
    assign wdWrite   = frameDone && frame.write && frame.addr == `WDB_ADDR_WATCHDOG;
    assign busWrite  = frameDone && frame.write && frame.addr == `WDB_ADDR_BUS;
    assign peakWrite = frameDone && frame.write && frame.addr == `WDB_ADDR_PEAK;
    assign wakeWrite = frameDone && frame.write && frame.addr == `WDB_ADDR_WAKE;
    assign parityBad = ^frame.data;

    // watchdog control next value
    always_comb begin
        watchdogControl_next = watchdogControl_reg;
        if (restartEntry) begin
            watchdogControl_next                       = watchdogControl_reg;
            watchdogControl_next[`WDB_WD_STOP_OFF_BIT] = 1'b0;
            watchdogControl_next[`WDB_WD_RSVD_BIT]     = 1'b0;
            watchdogControl_next[`WDB_WD_PERIOD_MSB:`WDB_WD_PERIOD_LSB] = `WDB_WD_RESTART_PERIOD;
        end else if (wdWrite && !parityBad) begin
            watchdogControl_next = frame.data & `WDB_WD_MASK;
        end
    end

    // bus transceiver control next value
    always_comb begin
        busTransceiverControl_next = busTransceiverControl_reg;
        if (failSafeEntry) begin
            busTransceiverControl_next[4:0] = `WDB_BUS_FAILSAFE_LOW;
        end else if (restartEntry) begin
            busTransceiverControl_next[`WDB_BUS_LIN_MSB:`WDB_BUS_LIN_LSB] = restartLinMode;
            busTransceiverControl_next[`WDB_BUS_RSVD_BIT]                 = 1'b0;
            busTransceiverControl_next[`WDB_BUS_CAN_MSB:`WDB_BUS_CAN_LSB] = restartCanMode;
        end else if (busWrite) begin
            busTransceiverControl_next = frame.data & `WDB_BUS_MASK;
        end
    end

    // supply peak control next value
    always_comb begin
        supplyPeakControl_next = supplyPeakControl_reg;
        if (failSafeEntry) begin
            supplyPeakControl_next = `WDB_PEAK_FAILSAFE;
        end else if (restartEntry) begin
            supplyPeakControl_next = supplyPeakControl_reg & `WDB_PEAK_MASK;
        end else if (peakWrite && (sbcMode == wdbus_pkg::SBC_INIT || sbcMode == wdbus_pkg::SBC_NORMAL)) begin
            supplyPeakControl_next = frame.data & `WDB_PEAK_MASK;
        end
    end

    // wake control next value
    always_comb begin
        wakeControl_next = wakeControl_reg;
        if (restartEntry) begin
            wakeControl_next = `WDB_WAKE_RESET;
        end else if (wakeWrite) begin
            wakeControl_next = frame.data & `WDB_WAKE_MASK;
        end
    end

    // watchdog control
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdogControl_reg <= `WDB_WD_RESET;
        end else if (softReset) begin
            watchdogControl_reg <= `WDB_WD_RESET;
        end else begin
            watchdogControl_reg <= watchdogControl_next;
        end
    end

    // bus transceiver control
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busTransceiverControl_reg <= `WDB_BUS_RESET;
        end else if (softReset) begin
            busTransceiverControl_reg <= `WDB_BUS_RESET;
        end else begin
            busTransceiverControl_reg <= busTransceiverControl_next;
        end
    end

    // supply peak control
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            supplyPeakControl_reg <= `WDB_PEAK_RESET;
        end else if (softReset) begin
            supplyPeakControl_reg <= `WDB_PEAK_RESET;
        end else begin
            supplyPeakControl_reg <= supplyPeakControl_next;
        end
    end

    // internal wake control
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wakeControl_reg <= `WDB_WAKE_RESET;
        end else if (softReset) begin
            wakeControl_reg <= `WDB_WAKE_RESET;
        end else begin
            wakeControl_reg <= wakeControl_next;
        end
    end

    // serial failure flag pulse
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            spiFail <= 1'b0;
        end else begin
            spiFail <= frameError || (wdWrite && parityBad);
        end
    end

    // watchdog settings toward the watchdog counter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stopWdogOff      <= 1'b0;
            windowTypeSelect <= 1'b0;
            periodSelect     <= 3'h4;
            periodMs         <= `WDB_PERIOD_MS_4;
        end else begin
            stopWdogOff      <= watchdogControl_next[`WDB_WD_STOP_OFF_BIT]
                              & wakeControl_next[`WDB_WAKE_STOP_OFF_BIT];
            windowTypeSelect <= watchdogControl_next[`WDB_WD_WINDOW_BIT];
            periodSelect     <= watchdogControl_next[`WDB_WD_PERIOD_MSB:`WDB_WD_PERIOD_LSB];
            periodMs         <= period_to_ms(
                watchdogControl_next[`WDB_WD_PERIOD_MSB:`WDB_WD_PERIOD_LSB]);
        end
    end

    // watchdog start on bus wake in stop mode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdogLongWindowStart <= 1'b0;
        end else begin
            wdogLongWindowStart <= busWake && sbcMode == wdbus_pkg::SBC_STOP
                                 && watchdogControl_reg[`WDB_WD_BUS_WAKE_BIT];
        end
    end

    // transceiver and supply peak settings
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            linCfg                 <= '0;
            firstLinMode           <= 2'h0;
            canMode                <= 2'h0;
            regulatorPeakThreshold <= 1'b0;
        end else begin
            linCfg.flash      <= busTransceiverControl_next[`WDB_BUS_FLASH_BIT];
            linCfg.lowSlope   <= busTransceiverControl_next[`WDB_BUS_LOW_SLOPE_BIT];
            linCfg.txdTimeout <= busTransceiverControl_next[`WDB_BUS_TXD_TO_BIT];
            firstLinMode      <= busTransceiverControl_next[`WDB_BUS_LIN_MSB:`WDB_BUS_LIN_LSB];
            canMode           <= busTransceiverControl_next[`WDB_BUS_CAN_MSB:`WDB_BUS_CAN_LSB];
            regulatorPeakThreshold <= supplyPeakControl_next[`WDB_PEAK_BIT];
        end
    end

endmodule : watchdog_bus_control_regs

// *** wdbus_ctrl_chk.sv ***
// assertion checker for the watchdog and bus control bank
`timescale 1ns/1ps
module wdbus_ctrl_chk (
    input wire logic                 sys_clk,
    input wire logic                 reset_n,
    input wire logic                 softReset,
    input wire logic                 restartEntry,
    input wire logic                 failSafeEntry,
    input wire wdbus_pkg::sbc_mode_e sbcMode,
    input wire logic [1:0]           restartLinMode,
    input wire logic [1:0]           restartCanMode,
    input wire logic                 busWake,
    input wire logic                 chip_select_n,
    input wire logic                 spiFail,
    input wire logic                 stopWdogOff,
    input wire logic                 windowTypeSelect,
    input wire logic                 wdogLongWindowStart,
    input wire logic [2:0]           periodSelect,
    input wire logic [9:0]           periodMs,
    input wire wdbus_pkg::lin_cfg_s  linCfg,
    input wire logic [1:0]           firstLinMode,
    input wire logic [1:0]           canMode,
    input wire logic                 regulatorPeakThreshold
);
    localparam logic [9:0] MS_TABLE [8] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h3E8, 10'h000};
    logic       csPrev;
    logic [3:0] csRiseHist;

    // recent chip select releases
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            csPrev     <= 1'b1;
            csRiseHist <= 4'h0;
        end else begin
            csPrev     <= chip_select_n;
            csRiseHist <= {csRiseHist[2:0], chip_select_n & ~csPrev};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence restartLoad;
        ##2 (periodSelect == 3'h4 && !stopWdogOff && windowTypeSelect == $past(windowTypeSelect, 2)
             && firstLinMode == $past(restartLinMode, 2) && canMode == $past(restartCanMode, 2)
             && linCfg == $past(linCfg, 2) && regulatorPeakThreshold == $past(regulatorPeakThreshold, 2));
    endsequence
    sequence failSafeLoad;
        ##2 (firstLinMode == 2'h1 && canMode == 2'h1 && !regulatorPeakThreshold && linCfg == $past(linCfg, 2));
    endsequence
    sequence softLoad;
        ##2 (periodSelect == 3'h4 && periodMs == 10'h0C8 && linCfg == 3'h1 && firstLinMode == 2'h0
             && canMode == 2'h0 && !windowTypeSelect && !stopWdogOff && !regulatorPeakThreshold);
    endsequence

    AST_PERIOD_MS: assert property (periodMs == MS_TABLE[periodSelect])
        else $error("period in ms does not match the period code");
    AST_LONG_WINDOW: assert property (wdogLongWindowStart |-> $past(busWake) && $past(sbcMode) == wdbus_pkg::SBC_STOP)
        else $error("long window start without a bus wake in stop");
    AST_PEAK_STOP: assert property ($changed(regulatorPeakThreshold) |-> $past(sbcMode) != wdbus_pkg::SBC_STOP
        || $past(softReset, 2) || $past(failSafeEntry))
        else $error("peak threshold changed by a write in stop");
    AST_LIN_CS: assert property ($changed(linCfg) |-> chip_select_n && $past(chip_select_n))
        else $error("lin options changed while chip select low");
    AST_FAIL_SAFE: assert property (failSafeEntry && !softReset |-> failSafeLoad)
        else $error("fail-safe reload values wrong");
    AST_RESTART: assert property (restartEntry && !failSafeEntry && !softReset |-> restartLoad)
        else $error("restart values wrong");
    AST_SOFT_RESET: assert property (softReset |-> softLoad)
        else $error("soft reset values wrong");
    AST_SPI_FAIL: assert property (spiFail |-> |csRiseHist)
        else $error("serial failure without a finished frame");
endmodule : wdbus_ctrl_chk

// *** wdbus_map.svh ***
// register offsets, field positions, reset and reload values of the control bank
`ifndef WDBUS_MAP_SVH
`define WDBUS_MAP_SVH

`define WDB_ADDR_WATCHDOG     7'h03
`define WDB_ADDR_BUS          7'h04
`define WDB_ADDR_PEAK         7'h05
`define WDB_ADDR_WAKE         7'h06

`define WDB_WD_CHECKSUM_BIT   7
`define WDB_WD_STOP_OFF_BIT   6
`define WDB_WD_WINDOW_BIT     5
`define WDB_WD_BUS_WAKE_BIT   4
`define WDB_WD_RSVD_BIT       3
`define WDB_WD_PERIOD_MSB     2
`define WDB_WD_PERIOD_LSB     0

`define WDB_BUS_FLASH_BIT     7
`define WDB_BUS_LOW_SLOPE_BIT 6
`define WDB_BUS_TXD_TO_BIT    5
`define WDB_BUS_LIN_MSB       4
`define WDB_BUS_LIN_LSB       3
`define WDB_BUS_RSVD_BIT      2
`define WDB_BUS_CAN_MSB       1
`define WDB_BUS_CAN_LSB       0

`define WDB_PEAK_BIT          5
`define WDB_WAKE_STOP_OFF_BIT 2

`define WDB_WD_RESET          8'h14
`define WDB_WD_RESTART_PERIOD 3'h4
`define WDB_BUS_RESET         8'h20
`define WDB_PEAK_RESET        8'h00
`define WDB_WAKE_RESET        8'h00
`define WDB_BUS_FAILSAFE_LOW  5'h09
`define WDB_PEAK_FAILSAFE     8'h01
`define WDB_WD_MASK           8'hF7
`define WDB_BUS_MASK          8'hFB
`define WDB_PEAK_MASK         8'h20
`define WDB_WAKE_MASK         8'h04

`define WDB_PERIOD_MS_0       10'h00A
`define WDB_PERIOD_MS_1       10'h014
`define WDB_PERIOD_MS_2       10'h032
`define WDB_PERIOD_MS_3       10'h064
`define WDB_PERIOD_MS_4       10'h0C8
`define WDB_PERIOD_MS_5       10'h1F4
`define WDB_PERIOD_MS_6       10'h3E8
`define WDB_PERIOD_MS_RSVD    10'h000

`define WDB_FRAME_BITS        5'h10
`define WDB_ADDR_BITS         5'h07

`endif

// *** wdbus_pkg.sv ***
// types shared by the control bank and its serial frame slave
package wdbus_pkg;

    typedef enum logic [2:0] {
        SBC_INIT,
        SBC_NORMAL,
        SBC_STOP,
        SBC_SLEEP,
        SBC_RESTART,
        SBC_FAILSAFE
    } sbc_mode_e;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } spi_frame_s;

    typedef struct packed {
        logic flash;
        logic lowSlope;
        logic txdTimeout;
    } lin_cfg_s;

endpackage : wdbus_pkg
